// ==== rtl/fsmc_dev.sv ====
// Supervisor end: sampling, fault protection, mode command decoding
//
// Overview of operation
// [RULE1] Input out of window 1 ms: all off
// [RULE2] Input trip acts like a full power cycle
// [RULE3] Sample all sensors every 200 us
// [RULE4] Output overvoltage pulls the alert line low
// [RULE5] Overvoltage: outputs off, retry every second
// [RULE6] Overcurrent: all outputs off, alert low
// [RULE7] Overcurrent: retry every second once cleared
// [RULE8] Either sensor at 95 C: outputs off
// [RULE9] Recover only after falling 20 C
// [RULE10] Manager sets warning bit; cleared at 85 C
// [RULE11] Open sense line keeps outputs off
// [RULE12] Bytes 66h 99h 10h select standalone
// [RULE13] Zero checksum byte then stop, verified
// [RULE14] Third byte 00h returns to sharing
// [RULE15] Three identical valid sequences commit mode
// [RULE16] Commit causes exactly one soft reboot
// [RULE17] Commits limited to 100000 lifetime; this design does not count commits or enforce the limit
// [RULE18] Uncommitted mode lost at power cycle
// [RULE19] Stored mode ships as current sharing
// [RULE20] Address byte 40h writes slot 0x20
// [RULE21] Slot address latched once at power-up
// [RULE22] Hold reset line low until ready
// [RULE23] Bad sequence or checksum is ignored
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
module fsmc_dev #(
   parameter int SAMPLE_CYC = fsmc_pkg::SAMPLE_CYC_DEF,
   parameter int RETRY_TICKS = fsmc_pkg::RETRY_TICKS_DEF
) (
   input wire logic pclk,
   input wire logic presetn,
   fsmc_link_if.dev lnk,
   input wire logic below_input_low_limit,
   input wire logic above_input_high_limit,
   input wire logic [1:0] out_ov,
   input wire logic [1:0] out_oc,
   input wire logic [1:0] sense_open,
   input wire logic [7:0] temp_a,
   input wire logic [7:0] temp_b,
   input wire logic slot_addr_bit0_n,
   input wire logic slot_addr_bit1_n,
   input wire logic nv_solo,
   output logic main_12v_rail_en,
   output logic aux_3v3_rail_en,
   output logic share_en,
   output logic nv_wr,
   output logic nv_wr_solo
);
   typedef struct packed {
      fsmc_pkg::fsmc_dst_t st;
      fsmc_pkg::fsmc_smp_t s1;
      fsmc_pkg::fsmc_smp_t s2;
      logic [2:0] bootc;
      logic [6:0] addr;
      logic solo;
      logic last_solo;
      logic [1:0] streak;
      fsmc_pkg::fsmc_div_t divc;
      fsmc_pkg::fsmc_ret_t retc;
      logic [2:0] winc;
      logic ov;
      logic oc;
      logic ot;
      logic so;
      logic warn;
      logic [2:0] nb;
      logic hit;
      logic rd;
      logic [3:0][7:0] b;
      logic rails;
      logic share;
      logic alert_o;
      logic alert_oe;
      logic hold_o;
      logic hold_oe;
      logic rsp_vld;
      logic [7:0] rsp;
      logic nvw;
      logic nvsolo;
   } fsmc_dev_st_t;

   fsmc_dev_st_t r;
   fsmc_dev_st_t n;
   logic tick;
   logic bad_in;
   logic [7:0] tmax;
   logic sel_ok;

   always_comb begin
      n = r;
      n.s1 = {temp_b, temp_a, slot_addr_bit1_n, slot_addr_bit0_n, sense_open, out_oc, out_ov,
         above_input_high_limit, below_input_low_limit};
      n.s2 = r.s1;
      n.nvw = 1'b0;
      n.rsp_vld = 1'b0;
      tick = (r.divc == fsmc_pkg::fsmc_div_t'(SAMPLE_CYC - 1)); // [RULE3]
      n.divc = tick ? '0 : fsmc_pkg::fsmc_div_t'(r.divc + 1'b1);
      bad_in = r.s2.lo || r.s2.hi;
      tmax = (r.s2.ta > r.s2.tb) ? r.s2.ta : r.s2.tb;
      sel_ok = (r.b[2] == fsmc_pkg::SEL_SOLO) || (r.b[2] == fsmc_pkg::SEL_SHARE);
      case (r.st)
         fsmc_pkg::D_BOOT: begin
            // Everything held off; comms ignored until the input is back in window
            n.rails = 1'b0;
            n.alert_oe = 1'b0;
            n.hold_oe = 1'b1; // [RULE22]
            n.ov = 1'b0;
            n.oc = 1'b0;
            n.ot = 1'b0;
            n.so = 1'b0;
            n.warn = 1'b0;
            n.streak = 2'h0;
            n.nb = 3'h0;
            n.hit = 1'b0;
            n.winc = 3'h0;
            n.retc = '0;
            if (r.bootc != 3'(fsmc_pkg::BOOT_CYC - 1)) begin
               n.bootc = 3'(r.bootc + 1'b1);
            end else if (!bad_in) begin // [RULE1]
               n.addr = fsmc_pkg::BASE_ADDR | {5'h00, !r.s2.ga1_n, !r.s2.ga0_n}; // [RULE21]
               n.solo = nv_solo; // [RULE18]
               n.share = !nv_solo;
               n.hold_oe = 1'b0; // [RULE22]
               n.st = fsmc_pkg::D_RUN;
            end
         end
         fsmc_pkg::D_RUN: begin
            if (tick) begin
               n.winc = bad_in ? 3'(r.winc + 1'b1) : 3'h0;
               if (r.ov || r.oc) begin
                  n.retc = (r.retc == fsmc_pkg::fsmc_ret_t'(RETRY_TICKS - 1)) ? '0 :
                     fsmc_pkg::fsmc_ret_t'(r.retc + 1'b1);
               end else begin
                  n.retc = '0;
               end
               if (|r.s2.ov) begin
                  n.ov = 1'b1; // [RULE4]
               end else if (r.ov && r.retc == fsmc_pkg::fsmc_ret_t'(RETRY_TICKS - 1)) begin
                  n.ov = 1'b0; // [RULE5]
               end
               if (|r.s2.oc) begin
                  n.oc = 1'b1; // [RULE6]
               end else if (r.oc && r.retc == fsmc_pkg::fsmc_ret_t'(RETRY_TICKS - 1)) begin
                  n.oc = 1'b0; // [RULE7]
               end
               if (tmax >= fsmc_pkg::OT_TRIP) begin
                  n.ot = 1'b1; // [RULE8]
               end else if (tmax <= 8'(fsmc_pkg::OT_TRIP - fsmc_pkg::OT_HYST)) begin
                  n.ot = 1'b0; // [RULE9]
               end
               if (tmax >= fsmc_pkg::OT_WARN) begin
                  n.warn = 1'b0; // [RULE10]
               end
               n.so = |r.s2.so; // [RULE11]
            end
            if (lnk.byte_vld) begin
               if (r.nb == 3'h0) begin
                  n.hit = (lnk.byte_dat[7:1] == r.addr);
                  n.rd = lnk.byte_dat[0];
                  if (lnk.byte_dat[7:1] == r.addr && lnk.byte_dat[0]) begin
                     n.rsp_vld = 1'b1;
                     n.rsp = {2'h0, r.warn, r.solo, r.so, r.ot, r.oc, r.ov};
                  end
               end else if (r.nb < 3'(fsmc_pkg::NB_LAST)) begin
                  n.b[2'(r.nb - 3'h1)] = lnk.byte_dat;
               end
               // Count one past a full frame so an overlong one never matches
               if (r.nb != 3'(fsmc_pkg::NB_LAST + 1)) begin
                  n.nb = 3'(r.nb + 1'b1);
               end
            end
            if (lnk.stop) begin
               n.nb = 3'h0;
               n.hit = 1'b0;
               // Anything not matching exactly falls through untouched
               if (r.hit && !r.rd && r.nb == 3'(fsmc_pkg::NB_LAST) && r.b[0] == fsmc_pkg::CMD_B1 &&
                  r.b[1] == fsmc_pkg::CMD_B2 && sel_ok &&
                  r.b[3] == fsmc_pkg::fsmc_zsum(r.b[0], r.b[1], r.b[2])) begin // [RULE12] [RULE13] [RULE23]
                  n.solo = (r.b[2] == fsmc_pkg::SEL_SOLO); // [RULE14]
                  n.share = (r.b[2] != fsmc_pkg::SEL_SOLO);
                  n.last_solo = n.solo;
                  n.streak = (r.streak != 2'h0 && r.last_solo == n.solo) ? 2'(r.streak + 1'b1) : 2'h1;
                  if (n.streak == fsmc_pkg::COMMIT_N) begin
                     n.nvw = 1'b1; // [RULE15]
                     n.nvsolo = n.solo;
                     n.bootc = 3'h0;
                     n.st = fsmc_pkg::D_BOOT; // [RULE16]
                  end
               end else if (r.hit && !r.rd && r.nb == 3'h4 && r.b[0] == fsmc_pkg::REG_STATUS &&
                  r.b[2] == fsmc_pkg::fsmc_zsum(r.b[0], r.b[1], 8'h00)) begin
                  // Manager write wins over a same-cycle hardware clear
                  n.warn = r.b[1][fsmc_pkg::ST_WARN]; // [RULE10]
               end
            end
            n.rails = !(n.ov || n.oc || n.ot || n.so); // [RULE6] [RULE8] [RULE11]
            n.alert_oe = n.ov || n.oc; // [RULE4] [RULE6]
            if (tick && bad_in && r.winc == 3'(fsmc_pkg::WIN_TICKS - 1)) begin
               n.rails = 1'b0; // [RULE1]
               n.alert_oe = 1'b0;
               n.hold_oe = 1'b1;
               n.bootc = 3'h0;
               n.st = fsmc_pkg::D_BOOT; // [RULE2]
            end
         end
         default: begin
            n.bootc = 3'h0;
            n.st = fsmc_pkg::D_BOOT;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
         r.hold_oe <= 1'b1; // [RULE22]
         r.share <= 1'b1; // [RULE19]
      end else begin
         r <= n;
      end
   end

   assign main_12v_rail_en = r.rails;
   assign aux_3v3_rail_en = r.rails;
   assign share_en = r.share;
   assign nv_wr = r.nvw;
   assign nv_wr_solo = r.nvsolo;
   assign lnk.rsp_vld = r.rsp_vld;
   assign lnk.rsp_dat = r.rsp;
   assign lnk.alert_o = r.alert_o;
   assign lnk.alert_oe = r.alert_oe;
   assign lnk.hold_o = r.hold_o;
   assign lnk.hold_oe = r.hold_oe;
endmodule : fsmc_dev

// ==== rtl/fsmc_pkg.sv ====
// Shared constants, types and helpers for the supervisor and its manager
package fsmc_pkg;
   localparam int CLK_MHZ = 50;
   localparam int SAMPLE_US = 200;
   localparam int SAMPLE_CYC_DEF = SAMPLE_US * CLK_MHZ;
   localparam int WIN_MS = 1;
   localparam int WIN_TICKS = (WIN_MS * 1000 + SAMPLE_US - 1) / SAMPLE_US;
   localparam int RETRY_S = 1;
   localparam int RETRY_TICKS_DEF = RETRY_S * 1000000 / SAMPLE_US;
   localparam int BOOT_CYC = 4;
   localparam int DIV_W = 14;
   localparam int RET_W = 13;
   localparam int NB_LAST = 5;
   // Temperatures in whole degrees C: 95, 20, 85
   localparam logic [7:0] OT_TRIP = 8'h5F;
   localparam logic [7:0] OT_HYST = 8'h14;
   localparam logic [7:0] OT_WARN = 8'h55;
   localparam logic [6:0] BASE_ADDR = 7'h20;
   localparam logic [7:0] CMD_B1 = 8'h66;
   localparam logic [7:0] CMD_B2 = 8'h99;
   localparam logic [7:0] SEL_SOLO = 8'h10;
   localparam logic [7:0] SEL_SHARE = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h55;
   localparam logic [1:0] COMMIT_N = 2'h3;
   localparam int ST_OV = 0;
   localparam int ST_OC = 1;
   localparam int ST_OT = 2;
   localparam int ST_SO = 3;
   localparam int ST_SOLO = 4;
   localparam int ST_WARN = 5;
   localparam logic [11:0] CTRL_OFS = 12'h000;
   localparam logic [11:0] STAT_OFS = 12'h004;
   localparam logic [1:0] OP_SHARE = 2'h0;
   localparam logic [1:0] OP_SOLO = 2'h1;
   localparam logic [1:0] OP_WARN = 2'h2;
   localparam logic [1:0] OP_READ = 2'h3;
   localparam int CTRL_GO = 8;
   typedef logic [DIV_W-1:0] fsmc_div_t;
   typedef logic [RET_W-1:0] fsmc_ret_t;
   typedef enum logic [1:0] {D_BOOT, D_RUN} fsmc_dst_t;
   typedef enum logic [1:0] {H_IDLE, H_SEND, H_STOP} fsmc_hst_t;
   typedef struct packed {
      logic [7:0] tb;
      logic [7:0] ta;
      logic ga1_n;
      logic ga0_n;
      logic [1:0] so;
      logic [1:0] oc;
      logic [1:0] ov;
      logic hi;
      logic lo;
   } fsmc_smp_t;

   function automatic logic [7:0] fsmc_zsum(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
      return 8'(8'h00 - a - b - c);
   endfunction : fsmc_zsum
endpackage : fsmc_pkg

// ==== rtl/fsmc_link_if.sv ====
// Byte link and open-drain lines between supervisor and manager
`timescale 1ns/1ps
interface fsmc_link_if;
   logic byte_vld;
   logic [7:0] byte_dat;
   logic stop;
   logic rsp_vld;
   logic [7:0] rsp_dat;
   logic alert_o;
   logic alert_oe;
   logic hold_o;
   logic hold_oe;
   logic alert_n;
   logic hold_n;

   // Pulled up unless driven low
   assign alert_n = !(alert_oe && !alert_o);
   assign hold_n = !(hold_oe && !hold_o);

   modport dev(input byte_vld, input byte_dat, input stop, output rsp_vld, output rsp_dat,
      output alert_o, output alert_oe, output hold_o, output hold_oe);
   modport host(output byte_vld, output byte_dat, output stop, input rsp_vld, input rsp_dat,
      input alert_n, input hold_n);
endinterface : fsmc_link_if

// ==== rtl/fsmc_host.sv ====
// Manager end: APB command registers driving the byte link
`timescale 1ns/1ps
module fsmc_host (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   fsmc_link_if.host lnk
);
   typedef struct packed {
      fsmc_pkg::fsmc_hst_t st;
      logic pend;
      logic [1:0] op;
      logic [1:0] slot;
      logic [4:0][7:0] fr;
      logic [2:0] len;
      logic [2:0] idx;
      logic [7:0] rsp;
      logic got;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic byte_vld;
      logic [7:0] byte_dat;
      logic stop;
   } fsmc_host_st_t;

   fsmc_host_st_t r;
   fsmc_host_st_t n;
   logic [7:0] aw;
   logic busy;

   always_comb begin
      n = r;
      n.pready = 1'b0;
      n.pslverr = 1'b0;
      n.byte_vld = 1'b0;
      n.stop = 1'b0;
      busy = r.pend || (r.st != fsmc_pkg::H_IDLE);
      aw = {fsmc_pkg::BASE_ADDR | {5'h00, r.slot}, 1'b0}; // [RULE20]
      if (psel && !penable) begin
         // Answer one cycle after setup; data is registered
         n.pready = 1'b1;
         if (paddr == fsmc_pkg::CTRL_OFS) begin
            n.prdata = {26'h000_0000, r.slot, 2'h0, r.op};
         end else if (paddr == fsmc_pkg::STAT_OFS) begin
            n.prdata = {16'h0000, r.rsp, 4'h0, r.got, !lnk.hold_n, !lnk.alert_n, busy};
         end else begin
            n.prdata = 32'h0000_0000;
            n.pslverr = 1'b1;
         end
      end
      if (psel && penable && r.pready && pwrite && paddr == fsmc_pkg::CTRL_OFS && !busy) begin
         n.op = pwdata[1:0];
         n.slot = pwdata[5:4];
         n.pend = pwdata[fsmc_pkg::CTRL_GO];
      end
      case (r.st)
         fsmc_pkg::H_IDLE: begin
            // Wait for the supervisor to release its hold line
            if (r.pend && lnk.hold_n) begin
               n.pend = 1'b0;
               n.idx = 3'h0;
               n.st = fsmc_pkg::H_SEND;
               if (r.op == fsmc_pkg::OP_READ) begin
                  n.got = 1'b0;
                  n.fr[0] = aw | 8'h01;
                  n.len = 3'h1;
               end else if (r.op == fsmc_pkg::OP_WARN) begin
                  n.fr[0] = aw;
                  n.fr[1] = fsmc_pkg::REG_STATUS;
                  n.fr[2] = 8'h20; // [RULE10]
                  n.fr[3] = fsmc_pkg::fsmc_zsum(fsmc_pkg::REG_STATUS, 8'h20, 8'h00);
                  n.len = 3'h4;
               end else begin
                  n.fr[0] = aw;
                  n.fr[1] = fsmc_pkg::CMD_B1; // [RULE12]
                  n.fr[2] = fsmc_pkg::CMD_B2;
                  n.fr[3] = (r.op == fsmc_pkg::OP_SOLO) ? fsmc_pkg::SEL_SOLO : fsmc_pkg::SEL_SHARE; // [RULE14]
                  n.fr[4] = fsmc_pkg::fsmc_zsum(fsmc_pkg::CMD_B1, fsmc_pkg::CMD_B2, n.fr[3]); // [RULE13]
                  n.len = 3'h5;
               end
            end
         end
         fsmc_pkg::H_SEND: begin
            n.byte_vld = 1'b1;
            n.byte_dat = r.fr[r.idx];
            if (r.idx == 3'(r.len - 1'b1)) begin
               n.st = fsmc_pkg::H_STOP;
            end else begin
               n.idx = 3'(r.idx + 1'b1);
            end
         end
         fsmc_pkg::H_STOP: begin
            n.stop = 1'b1; // [RULE13]
            n.st = fsmc_pkg::H_IDLE;
         end
         default: begin
            n.st = fsmc_pkg::H_IDLE;
         end
      endcase
      // Arrival wins over a same-cycle clear
      if (lnk.rsp_vld) begin
         n.rsp = lnk.rsp_dat;
         n.got = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign lnk.byte_vld = r.byte_vld;
   assign lnk.byte_dat = r.byte_dat;
   assign lnk.stop = r.stop;
endmodule : fsmc_host

// ==== verification/fsmc_properties.sv ====
// Concurrent checks on the link between supervisor and manager
`timescale 1ns/1ps
module fsmc_properties (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic byte_vld,
   input wire logic [7:0] byte_dat,
   input wire logic stop,
   input wire logic rsp_vld,
   input wire logic [7:0] rsp_dat,
   input wire logic alert_oe,
   input wire logic hold_oe,
   input wire logic main_12v_rail_en,
   input wire logic aux_3v3_rail_en,
   input wire logic share_en,
   input wire logic nv_wr
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_boot_hold;
      $rose(presetn) |-> hold_oe [*4];
   endproperty
   a_boot_hold: assert property (p_boot_hold) else $error("hold line released during boot");
   property p_boot_rails;
      hold_oe |-> !main_12v_rail_en && !aux_3v3_rail_en;
   endproperty
   a_boot_rails: assert property (p_boot_rails) else $error("rails on while held");
   property p_rails_pair;
      main_12v_rail_en == aux_3v3_rail_en;
   endproperty
   a_rails_pair: assert property (p_rails_pair) else $error("rails switched apart");
   property p_alert_off;
      $rose(alert_oe) |-> ##[0:2] !main_12v_rail_en;
   endproperty
   a_alert_off: assert property (p_alert_off) else $error("alert without shutdown");
   property p_read_rsp;
      byte_vld && byte_dat == {fsmc_pkg::BASE_ADDR, 1'b1} && !hold_oe |=> rsp_vld;
   endproperty
   a_read_rsp: assert property (p_read_rsp) else $error("read address not answered");
   property p_rsp_mode;
      rsp_vld |-> rsp_dat[4] == !share_en && rsp_dat[7:6] == 2'h0;
   endproperty
   a_rsp_mode: assert property (p_rsp_mode) else $error("status byte mode mismatch");
   property p_stop_order;
      stop |-> $past(byte_vld) && !byte_vld;
   endproperty
   a_stop_order: assert property (p_stop_order) else $error("stop not after last byte");
   // Boot reload is excluded: mode may load as the hold line is released
   property p_mode_frame;
      $changed(share_en) && !hold_oe && !$past(hold_oe) && !$past(hold_oe, 2) |-> $past(stop);
   endproperty
   a_mode_frame: assert property (p_mode_frame) else $error("mode changed outside frame");
   property p_nv_once;
      nv_wr |=> !nv_wr [*8];
   endproperty
   a_nv_once: assert property (p_nv_once) else $error("repeated commit write");
endmodule : fsmc_properties

// ==== verification/fault_supervisor_mode_ctrl_bench.sv ====
// Bench joining supervisor and manager, driven over APB
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; $display("Error at %0t: got %0h expected %0h", $time, g, e); end end
module fault_supervisor_mode_ctrl_bench;
   localparam int S = 20;
   localparam int RT = 3;
   logic pclk;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic lo;
   logic hi;
   logic [1:0] ov;
   logic [1:0] oc;
   logic [1:0] so;
   logic [7:0] ta;
   logic [7:0] tb;
   logic ga0_n;
   logic ga1_n;
   logic nv_solo = 1'b0;
   logic rail_main;
   logic rail_aux;
   logic share_en;
   logic nv_wr;
   logic nv_wr_solo;
   logic [31:0] q;
   logic err;
   logic [7:0] st;
   int n_fail;
   int num_checks;
   int n_nvw = 0;
   int n_rsp = 0;
   int k;

   fsmc_link_if lnk();
   fsmc_dev #(.SAMPLE_CYC(S), .RETRY_TICKS(RT)) u_fsmc_dev (.pclk(pclk), .presetn(presetn), .lnk(lnk),
      .below_input_low_limit(lo), .above_input_high_limit(hi), .out_ov(ov), .out_oc(oc), .sense_open(so),
      .temp_a(ta), .temp_b(tb), .slot_addr_bit0_n(ga0_n), .slot_addr_bit1_n(ga1_n), .nv_solo(nv_solo),
      .main_12v_rail_en(rail_main), .aux_3v3_rail_en(rail_aux), .share_en(share_en), .nv_wr(nv_wr),
      .nv_wr_solo(nv_wr_solo));
   fsmc_host u_fsmc_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk(lnk));
   fsmc_properties u_fsmc_properties (.pclk(pclk), .presetn(presetn), .byte_vld(lnk.byte_vld),
      .byte_dat(lnk.byte_dat), .stop(lnk.stop), .rsp_vld(lnk.rsp_vld), .rsp_dat(lnk.rsp_dat),
      .alert_oe(lnk.alert_oe), .hold_oe(lnk.hold_oe), .main_12v_rail_en(rail_main),
      .aux_3v3_rail_en(rail_aux), .share_en(share_en), .nv_wr(nv_wr));

   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   // Stored mode survives reset, as non-volatile memory would
   always @(posedge pclk) begin
      if (nv_wr === 1'b1) nv_solo <= nv_wr_solo;
      n_nvw <= n_nvw + int'(nv_wr === 1'b1);
      n_rsp <= n_rsp + int'(lnk.rsp_vld === 1'b1);
   end

   task automatic summarize();
      $display("checks %0d errors %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : summarize

   task automatic hang();
      n_fail++;
      $display("Error at %0t: wait timed out", $time);
      summarize();
   endtask : hang

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : cyc

   // Trailing idle cycle keeps back-to-back calls from driving psel twice in one step
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int i;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 20) hang();
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic ctrl(input logic [1:0] op, input logic [1:0] slot);
      int i;
      apb(1'b1, fsmc_pkg::CTRL_OFS, 32'h0000_0100 | {26'h000_0000, slot, 2'h0, op});
      cyc(2);
      for (i = 0; i < 20; i++) begin
         apb(1'b0, fsmc_pkg::STAT_OFS, 32'h0000_0000);
         if (q[0] === 1'b0) break;
      end
      if (i == 20) hang();
      cyc(3);
   endtask : ctrl

   task automatic status();
      ctrl(fsmc_pkg::OP_READ, 2'h0);
      apb(1'b0, fsmc_pkg::STAT_OFS, 32'h0000_0000);
      st = q[15:8];
   endtask : status

   task automatic wait_up();
      int i;
      for (i = 0; i < 100; i++) begin
         @(posedge pclk);
         if (lnk.hold_n === 1'b1) break;
      end
      if (i == 100) hang();
      cyc(2);
   endtask : wait_up

   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, lo, hi, ov, oc, so} = '0;
      ta = 8'h19;
      tb = 8'h19;
      {ga0_n, ga1_n} = 2'h3;
      {n_fail, num_checks} = '0;
      cyc(5);
      `CHK(lnk.hold_n, 1'b0)
      presetn <= 1'b1;
      wait_up();
      `CHK(share_en, 1'b1)
      `CHK(rail_main, 1'b1)
      apb(1'b0, 12'h0F0, 32'h0000_0000);
      `CHK(err, 1'b1)
      ctrl(fsmc_pkg::OP_SOLO, 2'h0);
      `CHK(share_en, 1'b0)
      status();
      `CHK(st[4], 1'b1)
      `CHK(q[3], 1'b1)
      `CHK(n_rsp, 1)
      ctrl(fsmc_pkg::OP_SHARE, 2'h1);
      `CHK(share_en, 1'b0)
      apb(1'b0, fsmc_pkg::CTRL_OFS, 32'h0000_0000);
      `CHK(q, 32'h0000_0010)
      // Three share frames in a row commit, then one reboot
      ctrl(fsmc_pkg::OP_SHARE, 2'h0);
      `CHK(share_en, 1'b1)
      ctrl(fsmc_pkg::OP_SHARE, 2'h0);
      `CHK(n_nvw, 0)
      ctrl(fsmc_pkg::OP_SHARE, 2'h0);
      wait_up();
      `CHK(n_nvw, 1)
      `CHK(nv_solo, 1'b0)
      `CHK(share_en, 1'b1)
      ctrl(fsmc_pkg::OP_SOLO, 2'h0);
      presetn <= 1'b0;
      cyc(5);
      presetn <= 1'b1;
      wait_up();
      `CHK(share_en, 1'b1)
      `CHK(n_nvw, 1)
      // Pins moved after power-up: the slot-0 address must still answer
      {ga0_n, ga1_n} <= 2'h0;
      status();
      `CHK(n_rsp, 2)
      {ga0_n, ga1_n} <= 2'h3;
      ctrl(fsmc_pkg::OP_WARN, 2'h0);
      ta <= fsmc_pkg::OT_WARN - 8'h01;
      cyc(3 * S);
      status();
      `CHK(st[5], 1'b1)
      ta <= fsmc_pkg::OT_WARN;
      cyc(3 * S);
      status();
      `CHK(st[5], 1'b0)
      ta <= 8'h19;
      tb <= fsmc_pkg::OT_TRIP;
      cyc(3 * S);
      `CHK(rail_main, 1'b0)
      `CHK(rail_aux, 1'b0)
      tb <= fsmc_pkg::OT_TRIP - fsmc_pkg::OT_HYST + 8'h01;
      cyc((RT + 3) * S);
      `CHK(rail_main, 1'b0)
      tb <= fsmc_pkg::OT_TRIP - fsmc_pkg::OT_HYST;
      cyc((RT + 3) * S);
      `CHK(rail_main, 1'b1)
      tb <= 8'h19;
      // Overvoltage, overcurrent, open sense in turn
      for (k = 0; k < 3; k++) begin
         ov <= (k == 0) ? 2'h1 : 2'h0;
         oc <= (k == 1) ? 2'h2 : 2'h0;
         so <= (k == 2) ? 2'h1 : 2'h0;
         cyc(3 * S);
         `CHK(rail_main, 1'b0)
         if (k < 2) begin
            `CHK(lnk.alert_n, 1'b0)
            apb(1'b0, fsmc_pkg::STAT_OFS, 32'h0000_0000);
            `CHK(q[1], 1'b1)
         end
         cyc((RT + 1) * S);
         `CHK(rail_main, 1'b0)
         {ov, oc, so} <= '0;
         cyc((RT + 3) * S);
         `CHK(rail_main, 1'b1)
         `CHK(lnk.alert_n, 1'b1)
      end
      ctrl(fsmc_pkg::OP_SOLO, 2'h0);
      ctrl(fsmc_pkg::OP_WARN, 2'h0);
      lo <= 1'b1;
      cyc(3 * S);
      lo <= 1'b0;
      `CHK(lnk.hold_n, 1'b1)
      cyc(2 * S);
      hi <= 1'b1;
      cyc(8 * S);
      `CHK(lnk.hold_n, 1'b0)
      `CHK(rail_main, 1'b0)
      apb(1'b0, fsmc_pkg::STAT_OFS, 32'h0000_0000);
      `CHK(q[2], 1'b1)
      hi <= 1'b0;
      wait_up();
      `CHK(share_en, 1'b1)
      `CHK(rail_main, 1'b1)
      status();
      `CHK(st[5], 1'b0)
      summarize();
   end
endmodule : fault_supervisor_mode_ctrl_bench
